// ---- verilog/dcapt_pkg.sv ----
`default_nettype none
package dcapt_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned DEC_W  = 12;
  localparam int unsigned SYNC_W = 12;

  // ------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [31:0] IDX_U0_CNT  = 32'h008003C0;
  localparam logic [31:0] IDX_U0_CAP3 = 32'h008003C2;
  localparam logic [31:0] IDX_U0_CAP2 = 32'h008003C4;
  localparam logic [31:0] IDX_U0_CAP1 = 32'h008003C6;
  localparam logic [31:0] IDX_U0_CAP0 = 32'h008003C8;
  localparam logic [31:0] IDX_U0_CTL  = 32'h008003CA;
  localparam logic [31:0] IDX_U1_CTL  = 32'h008003CB;
  localparam logic [31:0] IDX_U1_CNT  = 32'h008003D0;
  localparam logic [31:0] IDX_U1_CAP3 = 32'h008003D2;
  localparam logic [31:0] IDX_U1_CAP2 = 32'h008003D4;
  localparam logic [31:0] IDX_U1_CAP1 = 32'h008003D6;
  localparam logic [31:0] IDX_U1_CAP0 = 32'h008003D8;
  localparam logic [31:0] IDX_IRQ_ST  = 32'h008003E0;
  localparam logic [31:0] IDX_IRQ_CLR = 32'h008003E1;
  localparam logic [31:0] IDX_IRQ_EN  = 32'h008003E2;

  // ------------------------------------------------------------------
  // Control fields
  // ------------------------------------------------------------------
  localparam int unsigned U0_SS_LSB  = 0;
  localparam int unsigned U0_CKS_LSB = 4;
  localparam int unsigned U0_CEN_BIT = 7;
  localparam int unsigned U1_SS_LSB  = 8;
  localparam int unsigned U1_CKS_BIT = 13;
  localparam int unsigned U1_CEN_BIT = 15;
  localparam logic [31:0] U0_CTL_MASK = 32'h000000BF;
  localparam logic [31:0] U1_CTL_MASK = 32'h0000AF00;
  localparam logic [31:0] CTL_RST     = 32'h00000000;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

  // ------------------------------------------------------------------
  // Interrupt status layout
  // ------------------------------------------------------------------
  localparam int unsigned ST_OVF0    = 0;
  localparam int unsigned ST_OVF1    = 1;
  localparam int unsigned ST_PIN_LSB = 2;
  localparam int unsigned ST_W       = 6;
  localparam logic [ST_W-1:0] ST_RST = 6'h00;

  // Unit 0 count clock choices
  typedef enum logic [1:0] {
    DCAPT_CKS_EXT = 2'b00,
    DCAPT_CKS_CB0 = 2'b01,
    DCAPT_CKS_CB1 = 2'b10,
    DCAPT_CKS_CB3 = 2'b11
  } dcapt_cks_t;

endpackage : dcapt_pkg
`default_nettype wire

// ---- verilog/dcapt_unit.sv ----
`timescale 1ns/10ps
`default_nettype none
module dcapt_unit
  import dcapt_pkg::*;
#(
  parameter int unsigned W  = CNT_W,
  parameter int unsigned CH = NUM_CH
)(
  input  wire logic            clk_i,
  input  wire logic            arst_n_i,
  input  wire logic            ce_i,
  input  wire logic            tick_i,
  input  wire logic            run_i,
  input  wire logic            wr_i,
  input  wire logic [W-1:0]    wdata_i,
  input  wire logic [CH-1:0]   evt_i,
  output logic      [W-1:0]    count_o,
  output logic      [CH*W-1:0] cap_o,
  output logic                 ovf_o
);

  // ------------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------------
  logic [W-1:0] next_count;
  logic [W-1:0] cap_src;
  logic         step;

  // Written value beats the increment and is what gets captured
  assign step       = run_i & tick_i;
  assign next_count = wr_i ? wdata_i :
                      step ? W'(count_o + 1'b1) :
                      count_o;
  assign cap_src    = wr_i ? wdata_i : count_o;
  assign ovf_o      = step & ~wr_i & (&count_o);

  // Counter register, frozen while the clock enable is low
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      count_o <= CNT_RST;
    else if (ce_i)
      count_o <= next_count;
  end

  // ------------------------------------------------------------------
  // Capture registers, one per channel
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < CH; g++)
    begin : g_cap
      // Latch the shared count on the channel's event
      always_ff @(posedge clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          cap_o[g*W +: W] <= CNT_RST;
        else if (ce_i && evt_i[g])
          cap_o[g*W +: W] <= cap_src;
      end
    end
  endgenerate

endmodule : dcapt_unit
`default_nettype wire

// ---- verilog/dcapt_top.sv ----
// Our own choice: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Two units, each one 16-bit up-counter shared by four capture regs.
// - A unit counts once software sets its count-enable bit.
// - Clearing count-enable stops counting at once; the value then holds.
// - A selected event copies the unit's count into that channel's capture.
// - Counter overflow can raise a per-unit interrupt.
// - External event pins raise pin interrupts for the second unit only.
// - Counting steps on the selected count clock, so start is delayed.
// - Unit 0 bits 0-3: 0 no source, 1 event-bus line n.
// - Unit 0 bits 5:4 pick clock: pin, bus 0, bus 1, bus 3.
// - Unit 1 bits 8-11: 0 dedicated pin, 1 event-bus line n.
// - Unit 1 bit 13 picks clock bus 0 or clock bus 3.
// - Counters are read and written by software; reads see live count.
// - Capture registers are read-only and answer byte or halfword reads.
// - Event and counter write together: counter and capture take the value.
module dcapt_top
  import dcapt_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        ARST_N_I,
  input  wire logic        CE_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic        EXTERNAL_COUNT_CLOCK_PIN_I,
  input  wire logic        CLK_BUS0_I,
  input  wire logic        CLK_BUS1_I,
  input  wire logic        CLK_BUS3_I,
  input  wire logic [3:0]  EVENT_BUS_I,
  input  wire logic        U1_CH0_EVENT_PIN_I,
  input  wire logic        U1_CH1_EVENT_PIN_I,
  input  wire logic        U1_CH2_EVENT_PIN_I,
  input  wire logic        U1_CH3_EVENT_PIN_I,
  output logic             IRQ_O
);

  // ------------------------------------------------------------------
  // Input synchronisers and edge detect
  // ------------------------------------------------------------------
  // Bit order: ext clk, cb0, cb1, cb3, event bus 0-3, pins ch0-3
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [SYNC_W-1:0] sync_c;
  logic [SYNC_W-1:0] rise;

  assign raw_in = {U1_CH3_EVENT_PIN_I, U1_CH2_EVENT_PIN_I,
                   U1_CH1_EVENT_PIN_I, U1_CH0_EVENT_PIN_I,
                   EVENT_BUS_I, CLK_BUS3_I, CLK_BUS1_I, CLK_BUS0_I,
                   EXTERNAL_COUNT_CLOCK_PIN_I};

  // First stage is read only by the second stage
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
    end
    else if (CE_I)
    begin
      sync_a <= raw_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // Rising edges of the settled copies
  assign rise = sync_b & ~sync_c;

  logic       r_ext;
  logic       r_cb0;
  logic       r_cb1;
  logic       r_cb3;
  logic [3:0] r_evbus;
  logic [3:0] r_pin;

  assign r_ext   = rise[0];
  assign r_cb0   = rise[1];
  assign r_cb1   = rise[2];
  assign r_cb3   = rise[3];
  assign r_evbus = rise[7:4];
  assign r_pin   = rise[11:8];

  // ------------------------------------------------------------------
  // AHB-Lite address phase
  // ------------------------------------------------------------------
  logic             dp_valid;
  logic             dp_write;
  logic [DEC_W-1:0] dp_idx;
  logic [3:0]       dp_lanes;
  logic             ap_take;
  logic [DEC_W-1:0] ap_idx;
  logic [3:0]       ap_lanes;
  assign ap_take  = HSEL_I & HTRANS_I[1] & HREADY_I;
  assign ap_idx   = HADDR_I[DEC_W+1:2];
  // Byte lanes from size and low address bits
  assign ap_lanes = (HSIZE_I == 3'h0) ? (4'h1 << HADDR_I[1:0]) :
                    (HSIZE_I == 3'h1) ? (HADDR_I[1] ? 4'hC : 4'h3) :
                    4'hF;

  // Zero wait states: answer always ready and OKAY
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      dp_valid    <= 1'b0;
      dp_write    <= 1'b0;
      dp_idx      <= '0;
      dp_lanes    <= 4'h0;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
    else if (CE_I)
    begin
      dp_valid    <= ap_take;
      dp_write    <= HWRITE_I;
      dp_idx      <= ap_idx;
      dp_lanes    <= ap_lanes;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Write decode (data phase)
  // ------------------------------------------------------------------
  logic wr_act;
  logic wr_cnt0;
  logic wr_cnt1;
  logic wr_ctl0;
  logic wr_ctl1;
  logic wr_clr;
  logic wr_ien;

  // Counter writes are halfword; any low lane loads all 16 bits
  assign wr_act  = dp_valid & dp_write;
  assign wr_cnt0 = wr_act & (dp_idx == IDX_U0_CNT[DEC_W-1:0])
                   & (|dp_lanes[1:0]);
  assign wr_cnt1 = wr_act & (dp_idx == IDX_U1_CNT[DEC_W-1:0])
                   & (|dp_lanes[1:0]);
  assign wr_ctl0 = wr_act & (dp_idx == IDX_U0_CTL[DEC_W-1:0]) & dp_lanes[0];
  assign wr_ctl1 = wr_act & (dp_idx == IDX_U1_CTL[DEC_W-1:0]) & dp_lanes[1];
  assign wr_clr  = wr_act & (dp_idx == IDX_IRQ_CLR[DEC_W-1:0]);
  assign wr_ien  = wr_act & (dp_idx == IDX_IRQ_EN[DEC_W-1:0]);

  // ------------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------------
  logic [31:0] ctl0;
  logic [31:0] ctl1;

  // Unassigned bits are masked on write, so they stay zero
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      ctl0 <= CTL_RST;
      ctl1 <= CTL_RST;
    end
    else if (CE_I)
    begin
      if (wr_ctl0)
        ctl0 <= HWDATA_I & U0_CTL_MASK;
      if (wr_ctl1)
        ctl1 <= HWDATA_I & U1_CTL_MASK;
    end
  end

  logic [3:0] u0_source_sel;
  logic [3:0] u1_source_sel;
  dcapt_cks_t u0_clock_sel;
  logic       u1_clock_sel;
  logic       u0_count_enable;
  logic       u1_count_enable;

  assign u0_source_sel   = ctl0[U0_SS_LSB +: 4];
  assign u0_clock_sel    = dcapt_cks_t'(ctl0[U0_CKS_LSB +: 2]);
  assign u0_count_enable = ctl0[U0_CEN_BIT];
  assign u1_source_sel   = ctl1[U1_SS_LSB +: 4];
  assign u1_clock_sel    = ctl1[U1_CKS_BIT];
  assign u1_count_enable = ctl1[U1_CEN_BIT];

  // Enable written this cycle acts at once, so a start loses no step
  logic u0_run;
  logic u1_run;
  assign u0_run = wr_ctl0 ? HWDATA_I[U0_CEN_BIT] : u0_count_enable;
  assign u1_run = wr_ctl1 ? HWDATA_I[U1_CEN_BIT] : u1_count_enable;

  // ------------------------------------------------------------------
  // Count clock and event source selection
  // ------------------------------------------------------------------
  logic       u0_tick;
  logic       u1_tick;
  logic [3:0] u0_evt;
  logic [3:0] u1_evt;

  // Steps follow the sampled count clock, hence the start delay
  assign u0_tick = (u0_clock_sel == DCAPT_CKS_EXT) ? r_ext :
                   (u0_clock_sel == DCAPT_CKS_CB0) ? r_cb0 :
                   (u0_clock_sel == DCAPT_CKS_CB1) ? r_cb1 : r_cb3;
  assign u1_tick = u1_clock_sel ? r_cb3 : r_cb0;
  assign u0_evt  = u0_source_sel & r_evbus;
  assign u1_evt  = (u1_source_sel & r_evbus)
                   | (~u1_source_sel & r_pin);

  // ------------------------------------------------------------------
  // Capture units
  // ------------------------------------------------------------------
  logic [CNT_W-1:0]        u0_count;
  logic [CNT_W-1:0]        u1_count;
  logic [NUM_CH*CNT_W-1:0] u0_cap;
  logic [NUM_CH*CNT_W-1:0] u1_cap;
  logic                    u0_ovf;
  logic                    u1_ovf;
  dcapt_unit u_unit0 (
    .clk_i    (CLK_I),
    .arst_n_i (ARST_N_I),
    .ce_i     (CE_I),
    .tick_i   (u0_tick),
    .run_i    (u0_run),
    .wr_i     (wr_cnt0),
    .wdata_i  (HWDATA_I[CNT_W-1:0]),
    .evt_i    (u0_evt),
    .count_o  (u0_count),
    .cap_o    (u0_cap),
    .ovf_o    (u0_ovf)
  );

  dcapt_unit u_unit1 (
    .clk_i    (CLK_I),
    .arst_n_i (ARST_N_I),
    .ce_i     (CE_I),
    .tick_i   (u1_tick),
    .run_i    (u1_run),
    .wr_i     (wr_cnt1),
    .wdata_i  (HWDATA_I[CNT_W-1:0]),
    .evt_i    (u1_evt),
    .count_o  (u1_count),
    .cap_o    (u1_cap),
    .ovf_o    (u1_ovf)
  );

  // ------------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------------
  logic [ST_W-1:0] irq_status;
  logic [ST_W-1:0] irq_enable;
  logic [ST_W-1:0] irq_events;
  logic [ST_W-1:0] irq_clear;
  logic [ST_W-1:0] next_status;

  // Only unit 1 owns pins, so only it has pin interrupts
  assign irq_events  = {r_pin, u1_ovf, u0_ovf};
  assign irq_clear   = wr_clr ? HWDATA_I[ST_W-1:0] : ST_RST;
  // A new event wins over a clear in the same cycle
  assign next_status = (irq_status & ~irq_clear) | irq_events;

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      irq_status <= ST_RST;
      irq_enable <= ST_RST;
      IRQ_O      <= 1'b0;
    end
    else if (CE_I)
    begin
      irq_status <= next_status;
      if (wr_ien)
        irq_enable <= HWDATA_I[ST_W-1:0];
      IRQ_O      <= |(irq_status & irq_enable);
    end
  end

  // ------------------------------------------------------------------
  // Read data, sampled in the address phase
  // ------------------------------------------------------------------
  logic [31:0] next_rdata;
  logic [31:0] rd_mux;

  // Live count returned; captures read-only, any size returns all 16
  assign rd_mux =
    (ap_idx == IDX_U0_CNT[DEC_W-1:0])  ? {16'h0000, u0_count} :
    (ap_idx == IDX_U0_CAP3[DEC_W-1:0]) ? {16'h0000, u0_cap[63:48]} :
    (ap_idx == IDX_U0_CAP2[DEC_W-1:0]) ? {16'h0000, u0_cap[47:32]} :
    (ap_idx == IDX_U0_CAP1[DEC_W-1:0]) ? {16'h0000, u0_cap[31:16]} :
    (ap_idx == IDX_U0_CAP0[DEC_W-1:0]) ? {16'h0000, u0_cap[15:0]} :
    (ap_idx == IDX_U0_CTL[DEC_W-1:0])  ? ctl0 :
    (ap_idx == IDX_U1_CTL[DEC_W-1:0])  ? ctl1 :
    (ap_idx == IDX_U1_CNT[DEC_W-1:0])  ? {16'h0000, u1_count} :
    (ap_idx == IDX_U1_CAP3[DEC_W-1:0]) ? {16'h0000, u1_cap[63:48]} :
    (ap_idx == IDX_U1_CAP2[DEC_W-1:0]) ? {16'h0000, u1_cap[47:32]} :
    (ap_idx == IDX_U1_CAP1[DEC_W-1:0]) ? {16'h0000, u1_cap[31:16]} :
    (ap_idx == IDX_U1_CAP0[DEC_W-1:0]) ? {16'h0000, u1_cap[15:0]} :
    (ap_idx == IDX_IRQ_ST[DEC_W-1:0])  ? {26'h0000000, irq_status} :
    (ap_idx == IDX_IRQ_EN[DEC_W-1:0])  ? {26'h0000000, irq_enable} :
    32'h00000000;
  assign next_rdata = (ap_take && !HWRITE_I) ? rd_mux : 32'h00000000;

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      HRDATA_O <= 32'h00000000;
    else if (CE_I)
      HRDATA_O <= next_rdata;
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  a_cnt_stop_hold: assert property (
    CE_I && !u0_run && !wr_cnt0 |=> u0_count == $past(u0_count))
    else $error("unit 0 counter moved while stopped");
  a_cnt_step_one: assert property (
    CE_I && u0_run && u0_tick && !wr_cnt0
    |=> u0_count == CNT_W'($past(u0_count) + 1'b1))
    else $error("unit 0 counter did not step by one");
  a_cnt_wrap_zero: assert property (
    CE_I && u0_run && u0_tick && !wr_cnt0 && (&u0_count)
    |=> u0_count == CNT_RST && irq_status[ST_OVF0])
    else $error("unit 0 wrap or overflow flag wrong");
  a_cap_takes_cnt: assert property (
    CE_I && u1_evt[2] && !wr_cnt1 |=> u1_cap[47:32] == $past(u1_count))
    else $error("capture did not take the count");
  a_cap_write_same: assert property (
    CE_I && wr_cnt0 && u0_evt[0] |=> u0_cap[15:0] == $past(HWDATA_I[15:0])
        && u0_count == $past(HWDATA_I[15:0]))
    else $error("write and event in one cycle mishandled");
  a_u0_no_source: assert property (!u0_source_sel[1] |-> !u0_evt[1])
    else $error("unit 0 channel fired without a source");
  a_u1_pin_source: assert property (
    !u1_source_sel[3] && r_pin[3] |-> u1_evt[3])
    else $error("unit 1 pin event lost");
  a_u1_clock_sel: assert property (
    u1_clock_sel && r_cb0 && !r_cb3 |-> !u1_tick)
    else $error("unit 1 stepped on the wrong clock");
  a_u0_clock_ext: assert property (
    u0_clock_sel == DCAPT_CKS_EXT |-> u0_tick == r_ext)
    else $error("unit 0 clock select wrong");
  a_pin_irq_set: assert property (
    CE_I && r_pin[0] |=> irq_status[ST_PIN_LSB]
    and (CE_I && irq_enable[ST_PIN_LSB] |=> IRQ_O))
    else $error("pin interrupt not raised");
  a_ctl_reserved: assert property (
    (ctl0 & ~U0_CTL_MASK) == 32'h0 && (ctl1 & ~U1_CTL_MASK) == 32'h0)
    else $error("unassigned control bit set");
  c_overflow:  cover property (u0_ovf ##[1:4] IRQ_O);
  c_wr_evt:    cover property (wr_cnt0 && u0_evt[0]);
  c_pin_cap:   cover property (!u1_source_sel[0] && u1_evt[0]);
  c_stop_run:  cover property (u0_count_enable && wr_ctl0 && !u0_run);
endmodule : dcapt_top
`default_nettype wire

// ---- verification/dcapt_far_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Far side: count clock lines, event bus and unit 1 pins
// ------------------------------------------------------------
module dcapt_far_model
(
  output logic [3:0] clk_line_o,
  output logic [3:0] evt_bus_o,
  output logic [3:0] pin_o
);
  logic [7:0] evt;

  // Bus lines low, pins high nibble
  assign evt_bus_o = evt[3:0];
  assign pin_o     = evt[7:4];

  // Everything idles low; count clocks stand still between bursts
  initial
  begin
    clk_line_o = 4'h0;
    evt        = 8'h00;
  end

  // Burst of count clock periods, 125 ns each, off the system phase
  task automatic burst(input int line, input int n);
    repeat (n)
    begin
      #62.5 clk_line_o[line] = 1'b1;
      #62.5 clk_line_o[line] = 1'b0;
    end
  endtask : burst

  // One rising edge; wide enough for the 2-flop synchroniser
  task automatic fire(input int k);
    #13 evt[k] = 1'b1;
    #40 evt[k] = 1'b0;
    #40;
  endtask : fire
endmodule : dcapt_far_model
`default_nettype wire

// ---- verification/test_dual_16bit_input_capture_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_dual_16bit_input_capture_timer
  import dcapt_pkg::*;
;
  logic        clk, arst_n, hwrite, hready, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  cl, eb, pn;
  int          num_errors, n_tests;

  dcapt_top i_dcapt_top (
    .CLK_I(clk), .ARST_N_I(arst_n), .CE_I(1'b1), .HSEL_I(1'b1),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .EXTERNAL_COUNT_CLOCK_PIN_I(cl[0]), .CLK_BUS0_I(cl[1]),
    .CLK_BUS1_I(cl[2]), .CLK_BUS3_I(cl[3]), .EVENT_BUS_I(eb),
    .U1_CH0_EVENT_PIN_I(pn[0]), .U1_CH1_EVENT_PIN_I(pn[1]),
    .U1_CH2_EVENT_PIN_I(pn[2]), .U1_CH3_EVENT_PIN_I(pn[3]),
    .IRQ_O(irq));

  dcapt_far_model i_dcapt_far_model (
    .clk_line_o(cl), .evt_bus_o(eb), .pin_o(pn));

  // ------------------------------------------------------------
  // Bus master and comparison
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: 0x%h vs 0x%h", $time, got, exp);
      num_errors++;
    end
  endtask : chk

  // Single word transfer; waits on hready, no cycle count assumed
  task automatic xfer(input logic wr, input logic [31:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    haddr  <= idx << 2;
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [31:0] idx, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, idx, d, x);
  endtask : wr

  task automatic rd(input logic [31:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    xfer(1'b0, idx, 32'h0, x);
    chk(x, exp);
  endtask : rd

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd(IDX_U0_CTL, 32'h0);
    rd(IDX_U1_CTL, 32'h0);
    rd(IDX_IRQ_ST, 32'h0);
    chk({29'h0, hready, hresp, irq}, 32'h4);
  endtask : t_reset

  // Unassigned control bits, counter write path, read-only captures
  task automatic t_regs;
    wr(IDX_U0_CTL, 32'hFFFFFFFF);
    rd(IDX_U0_CTL, 32'h000000BF);
    wr(IDX_U1_CTL, 32'hFFFFFFFF);
    rd(IDX_U1_CTL, 32'h0000AF00);
    wr(IDX_U0_CTL, 32'h0);
    wr(IDX_U1_CTL, 32'h0);
    wr(IDX_U1_CNT, 32'hA5A5FFFE);
    rd(IDX_U1_CNT, 32'h0000FFFE);
    wr(IDX_U0_CAP0, 32'h00001234);
    rd(IDX_U0_CAP0, 32'h0);
  endtask : t_regs

  // Selected line counts, a foreign line does not, stop holds value
  task automatic t_count(input logic [31:0] cnt, input logic [31:0] ctl,
                         input logic [31:0] on, input int line);
    wr(cnt, 32'h0);
    wr(ctl, on);
    fork
      i_dcapt_far_model.burst(line, 5);
      i_dcapt_far_model.burst((line + 1) % 4, 2);
    join
    repeat (8) @(posedge clk);
    wr(ctl, 32'h0);
    i_dcapt_far_model.burst(line, 3);
    repeat (8) @(posedge clk);
    rd(cnt, 32'h5);
  endtask : t_count

  // Wrap past the top, sticky status, masking and clearing
  task automatic t_ovf;
    wr(IDX_IRQ_EN, 32'h1);
    wr(IDX_U0_CNT, 32'h0000FFFE);
    wr(IDX_U0_CTL, 32'h00000090);
    i_dcapt_far_model.burst(1, 3);
    repeat (8) @(posedge clk);
    wr(IDX_U0_CTL, 32'h0);
    rd(IDX_U0_CNT, 32'h1);
    rd(IDX_IRQ_ST, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_EN, 32'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_CLR, 32'h1);
    rd(IDX_IRQ_ST, 32'h0);
  endtask : t_ovf

  // One event on line k, then the channel's capture is read back
  task automatic t_cap(input logic [31:0] cnt, input logic [31:0] ctl,
                       input logic [31:0] cap0, input logic [31:0] on,
                       input int k, input int n, input logic [31:0] v,
                       input logic [31:0] exp);
    wr(cnt, v);
    wr(ctl, on);
    i_dcapt_far_model.fire(k);
    repeat (8) @(posedge clk);
    rd(cap0 - 32'(2 * n), exp);
  endtask : t_cap

  // Counter write lands in the cycle the channel 0 event acts:
  // event-bus line 0 edge at +13 ns acts at the 6th edge, write data phase ends there
  task automatic t_same;
    wr(IDX_U0_CTL, 32'h1);
    @(posedge clk);
    fork
      i_dcapt_far_model.fire(0);
      begin
        repeat (3) @(posedge clk);
        wr(IDX_U0_CNT, 32'h00002345);
      end
    join
    repeat (8) @(posedge clk);
    rd(IDX_U0_CAP0, 32'h2345);
    rd(IDX_U0_CNT, 32'h2345);
  endtask : t_same

  // Clock, time-zero inputs, reset held for 12 cycles
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Main sequence
  initial
  begin
    arst_n = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_regs();
    for (int s = 0; s < 4; s++)
      t_count(IDX_U0_CNT, IDX_U0_CTL, 32'h80 | 32'(s << 4), s);
    t_count(IDX_U1_CNT, IDX_U1_CTL, 32'h8000, 1);
    t_count(IDX_U1_CNT, IDX_U1_CTL, 32'hA000, 3);
    t_ovf();
    for (int n = 0; n < 4; n++)
    begin
      t_cap(IDX_U0_CNT, IDX_U0_CTL, IDX_U0_CAP0, 32'h8F, n, n,
            32'(256 + n), 32'(256 + n));
      t_cap(IDX_U0_CNT, IDX_U0_CTL, IDX_U0_CAP0, 32'h80, n, n,
            32'hBEEF, 32'(256 + n));
      t_cap(IDX_U1_CNT, IDX_U1_CTL, IDX_U1_CAP0, 32'h8000, n + 4, n,
            32'(512 + n), 32'(512 + n));
      t_cap(IDX_U1_CNT, IDX_U1_CTL, IDX_U1_CAP0, 32'h8F00, n, n,
            32'(768 + n), 32'(768 + n));
      t_cap(IDX_U1_CNT, IDX_U1_CTL, IDX_U1_CAP0, 32'h8F00, n + 4, n,
            32'h4444, 32'(768 + n));
    end
    t_same();
    rd(IDX_IRQ_ST, 32'h3C);
    print_verdict();
  end

  // Hang guard, well beyond the expected run
  initial
  begin
    #100000;
    num_errors++;
    print_verdict();
  end

  task automatic print_verdict;
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
endmodule : test_dual_16bit_input_capture_timer
`default_nettype wire
